// ---- rtl/oag_regs.svh ----
// Constants for the operand address generator: bit positions, reset values, counts
`ifndef OAG_REGS_SVH
`define OAG_REGS_SVH
// Oscillator cycles per bus-rate cycle, two or more
`define OAG_CLK_DIV 2
// Condition flag bit positions
`define OAG_FLAG_V 7
`define OAG_FLAG_H 4
`define OAG_FLAG_I 3
`define OAG_FLAG_N 2
`define OAG_FLAG_Z 1
`define OAG_FLAG_C 0
// Reset values
`define OAG_RST_ACC 8'h00
`define OAG_RST_IDX 16'h0000
`define OAG_RST_SP 16'h00ff
`define OAG_RST_PC 16'h0000
`define OAG_RST_FLAGS 8'h08
// Direct page high byte
`define OAG_DIRECT_HI 8'h00
// Interrupt source numbers
`define OAG_SRC_TRAP 7'h00
`define OAG_SRC_EXT 7'h01
// Decimal adjust thresholds and corrections
`define OAG_BCD_LO_MAX 4'h9
`define OAG_BCD_HI_MAX 8'h99
`define OAG_BCD_LO_FIX 8'h06
`define OAG_BCD_HI_FIX 8'h60
`endif

// ---- rtl/oag_pkg.sv ----
// Types shared by the operand address generator and its bench
package oag_pkg;
   typedef enum logic [3:0] {
      OAG_IMM = 4'h0, OAG_DIR = 4'h1, OAG_EXT = 4'h2, OAG_IX0 = 4'h3,
      OAG_IX1 = 4'h4, OAG_IX2 = 4'h5, OAG_IXP0 = 4'h6, OAG_IXP1 = 4'h7,
      OAG_INH = 4'h8, OAG_MM = 4'h9
   } oag_mode_t;
   // Memory-to-memory variants: source -> destination
   typedef enum logic [1:0] {
      OAG_MM_IMM_DIR = 2'h0, OAG_MM_DIR_DIR = 2'h1,
      OAG_MM_IXP_DIR = 2'h2, OAG_MM_DIR_IXP = 2'h3
   } oag_mm_t;
   typedef enum logic [2:0] {
      OAG_SEL_ACC = 3'h0, OAG_SEL_IDXH = 3'h1, OAG_SEL_IDXL = 3'h2,
      OAG_SEL_IDX = 3'h3, OAG_SEL_SP = 3'h4, OAG_SEL_PC = 3'h5
   } oag_sel_t;
   typedef struct packed {
      oag_mode_t mode;
      logic wide;
      logic store;
      oag_mm_t mm;
   } oag_cmd_t;
   typedef struct packed {
      logic en;
      oag_sel_t sel;
      logic [15:0] data;
   } oag_regwr_t;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic rd;
      logic wr;
   } oag_mem_t;
endpackage : oag_pkg

// ---- rtl/oag_core.sv ----
// Operand fetch, effective address generation and register set of an 8-bit core
//
// Summary of operation
// - Memory accesses advance once per bus-rate cycle, the clock divided by two or more.
// - Holds accumulator, index pair, stack pointer, program counter and condition flags.
// - Index pair halves are written separately; pair serves as base and storage.
// - Direct mode: one program byte is the low address, high byte zero.
// - Extended mode: first byte after opcode is high address, second is low.
// - Immediate mode fetches one or two operand bytes by destination width.
// - Indexed mode address is index pair plus zero, one or two offset bytes.
// - Post-increment mode adds zero or one offset byte, then increments index.
// - Inherent mode takes no operand bytes and finishes at once.
// - Memory-to-memory moves bypass the accumulator entirely.
// - Four move variants: immediate, direct or indexed source.
// - Mask flag set blocks maskable requests; clear lets pending ones through.
// - Half-carry records low-nibble carry; decimal adjust uses it with carry.
// - Interrupt source number spans 128 values, the software trap among them.
// - External request pin is active low.
// - Writes drive address, data and the write strobe together, one byte each.
// - Reads drive address and read strobe; memory returns its byte.
`timescale 1ns/1ps
`include "oag_regs.svh"
module oag_core (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic cmd_valid_i,
   input wire oag_pkg::oag_cmd_t cmd_i,
   output logic cmd_ready_o,
   output logic done_o,
   output logic [15:0] operand_o,
   output logic [15:0] ea_o,
   output oag_pkg::oag_mem_t mem_o,
   input wire logic [7:0] rdata_i,
   input wire oag_pkg::oag_regwr_t regwr_i,
   input wire logic add_en_i,
   input wire logic [7:0] add_data_i,
   input wire logic add_carry_i,
   input wire logic daa_en_i,
   input wire logic mask_set_i,
   input wire logic mask_clr_i,
   input wire logic irq_n_i,
   input wire logic periph_req_i,
   input wire logic [6:0] periph_src_i,
   input wire logic software_trap_i,
   input wire logic irq_ack_i,
   output logic irq_req_o,
   output logic [6:0] irq_src_o,
   output logic [7:0] acc_o,
   output logic [15:0] index_o,
   output logic [15:0] stack_pointer_o,
   output logic [15:0] program_counter_o,
   output logic [7:0] condition_flags_o
);
   import oag_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_FETCH = 3'b001, S_EA = 3'b010,
      S_DATA = 3'b011, S_SRC = 3'b100, S_DST = 3'b101
   } oag_state_t;

   // Operand bytes that follow the opcode for each mode
   function automatic logic [1:0] oag_nbytes(input oag_cmd_t c);
      logic [1:0] n;
      n = 2'd0;
      unique case (c.mode)
         OAG_IMM: n = c.wide ? 2'd2 : 2'd1;
         OAG_DIR, OAG_IX1, OAG_IXP1: n = 2'd1;
         OAG_EXT, OAG_IX2: n = 2'd2;
         OAG_IX0, OAG_IXP0, OAG_INH: n = 2'd0;
         OAG_MM: n = (c.mm == OAG_MM_IMM_DIR || c.mm == OAG_MM_DIR_DIR) ? 2'd2 : 2'd1;
         default: n = 2'd0;
      endcase
      return n;
   endfunction : oag_nbytes

   logic [7:0] acc;
   logic [15:0] idx;
   logic [15:0] stack_pointer_reg;
   logic [15:0] program_counter_reg;
   logic [7:0] condition_flags_reg;
   oag_state_t state;
   oag_cmd_t cmd;
   logic [1:0] nbytes;
   logic [1:0] got;
   logic [7:0] b0;
   logic [7:0] b1;
   logic [7:0] mm_data;
   logic [15:0] dst;
   logic xfer;
   logic pc_inc;
   logic idx_inc;
   logic [15:0] access_addr;
   logic [15:0] next_ea;
   logic [$clog2(`OAG_CLK_DIV)-1:0] div_cnt;
   logic bus_en;
   logic irq_meta;
   logic irq_sync_n;
   logic trap_pend;

   // Bus-rate enable: one pulse every divider period
   always_ff @(posedge mclk_i) begin
      if (srst_i || div_cnt == ($clog2(`OAG_CLK_DIV))'(`OAG_CLK_DIV - 1)) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end
   assign bus_en = (div_cnt == ($clog2(`OAG_CLK_DIV))'(`OAG_CLK_DIV - 1));

   // Effective address from mode, fetched bytes and index pair; carries drop off
   always_comb begin
      next_ea = 16'h0000;
      unique case (cmd.mode)
         OAG_DIR: next_ea = {`OAG_DIRECT_HI, b0};
         OAG_EXT: next_ea = {b0, b1};
         OAG_IX0, OAG_IXP0: next_ea = idx;
         OAG_IX1, OAG_IXP1: next_ea = 16'(idx + {8'h00, b0});
         OAG_IX2: next_ea = 16'(idx + {b0, b1});
         OAG_MM: next_ea = (cmd.mm == OAG_MM_IXP_DIR) ? idx : {`OAG_DIRECT_HI, b0};
         default: next_ea = 16'h0000;
      endcase
   end

   // Address driven during the current access
   always_comb begin
      unique case (state)
         S_FETCH: access_addr = program_counter_reg;
         S_DST: access_addr = dst;
         default: access_addr = ea_o;
      endcase
   end

   assign cmd_ready_o = (state == S_IDLE);

   // Access sequencer: each access holds its strobe for one whole bus cycle
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state <= S_IDLE;
         cmd <= '0;
         nbytes <= 2'd0;
         got <= 2'd0;
         b0 <= 8'h00;
         b1 <= 8'h00;
         mm_data <= 8'h00;
         dst <= 16'h0000;
         xfer <= 1'b0;
         mem_o <= '0;
         pc_inc <= 1'b0;
         idx_inc <= 1'b0;
         done_o <= 1'b0;
         operand_o <= 16'h0000;
         ea_o <= 16'h0000;
      end else begin
         done_o <= 1'b0;
         pc_inc <= 1'b0;
         idx_inc <= 1'b0;
         unique case (state)
            S_IDLE: begin
               if (cmd_valid_i) begin
                  cmd <= cmd_i;
                  nbytes <= oag_nbytes(cmd_i);
                  got <= 2'd0;
                  state <= (oag_nbytes(cmd_i) == 2'd0) ? S_EA : S_FETCH;
               end
            end
            S_EA: begin
               ea_o <= next_ea;
               if (cmd.mode == OAG_IMM) begin
                  operand_o <= cmd.wide ? {b0, b1} : {8'h00, b0};
                  done_o <= 1'b1;
                  state <= S_IDLE;
               end else if (cmd.mode == OAG_INH) begin
                  done_o <= 1'b1;
                  state <= S_IDLE;
               end else if (cmd.mode == OAG_MM) begin
                  // Destination is direct page except for the indexed-store variant
                  if (cmd.mm == OAG_MM_DIR_IXP) begin
                     dst <= idx;
                  end else if (cmd.mm == OAG_MM_IXP_DIR) begin
                     dst <= {`OAG_DIRECT_HI, b0};
                  end else begin
                     dst <= {`OAG_DIRECT_HI, b1};
                  end
                  mm_data <= b0;
                  state <= (cmd.mm == OAG_MM_IMM_DIR) ? S_DST : S_SRC;
               end else begin
                  state <= S_DATA;
               end
            end
            default: begin
               if (bus_en && !xfer) begin
                  // Address and data settle with the strobe for a full bus cycle
                  xfer <= 1'b1;
                  mem_o.addr <= access_addr;
                  mem_o.wdata <= (state == S_DST) ? mm_data : acc;
                  mem_o.wr <= (state == S_DST) || (state == S_DATA && cmd.store);
                  mem_o.rd <= !((state == S_DST) || (state == S_DATA && cmd.store));
               end else if (bus_en) begin
                  xfer <= 1'b0;
                  mem_o.rd <= 1'b0;
                  mem_o.wr <= 1'b0;
                  unique case (state)
                     S_FETCH: begin
                        if (got == 2'd0) begin
                           b0 <= rdata_i;
                        end else begin
                           b1 <= rdata_i;
                        end
                        pc_inc <= 1'b1;
                        got <= got + 2'd1;
                        if (got + 2'd1 == nbytes) begin
                           state <= S_EA;
                        end
                     end
                     S_DATA: begin
                        if (!cmd.store) begin
                           operand_o <= {8'h00, rdata_i};
                        end
                        idx_inc <= (cmd.mode == OAG_IXP0 || cmd.mode == OAG_IXP1);
                        done_o <= 1'b1;
                        state <= S_IDLE;
                     end
                     S_SRC: begin
                        mm_data <= rdata_i;
                        idx_inc <= (cmd.mm == OAG_MM_IXP_DIR);
                        state <= S_DST;
                     end
                     default: begin
                        idx_inc <= (cmd.mm == OAG_MM_DIR_IXP);
                        done_o <= 1'b1;
                        state <= S_IDLE;
                     end
                  endcase
               end
            end
         endcase
      end
   end

   // Index pair: sequencer increment takes precedence over a port write
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         idx <= `OAG_RST_IDX;
      end else if (idx_inc) begin
         idx <= 16'(idx + 16'h0001);
      end else if (regwr_i.en) begin
         unique case (regwr_i.sel)
            OAG_SEL_IDXH: idx[15:8] <= regwr_i.data[7:0];
            OAG_SEL_IDXL: idx[7:0] <= regwr_i.data[7:0];
            OAG_SEL_IDX: idx <= regwr_i.data;
            default: idx <= idx;
         endcase
      end
   end

   // Program counter and stack pointer
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         program_counter_reg <= `OAG_RST_PC;
         stack_pointer_reg <= `OAG_RST_SP;
      end else begin
         if (pc_inc) begin
            program_counter_reg <= 16'(program_counter_reg + 16'h0001);
         end else if (regwr_i.en && regwr_i.sel == OAG_SEL_PC) begin
            program_counter_reg <= regwr_i.data;
         end
         if (regwr_i.en && regwr_i.sel == OAG_SEL_SP) begin
            stack_pointer_reg <= regwr_i.data;
         end
      end
   end

   // Accumulator and arithmetic flags; decimal adjust wins over add if both pulse
   logic [8:0] add_sum;
   logic [4:0] add_lo;
   logic [7:0] daa_fix;
   logic [8:0] daa_sum;
   logic daa_carry;
   always_comb begin
      add_sum = {1'b0, acc} + {1'b0, add_data_i} + {8'h00, add_carry_i};
      add_lo = {1'b0, acc[3:0]} + {1'b0, add_data_i[3:0]} + {4'h0, add_carry_i};
      daa_carry = condition_flags_reg[`OAG_FLAG_C] || (acc > `OAG_BCD_HI_MAX);
      daa_fix = 8'h00;
      if (condition_flags_reg[`OAG_FLAG_H] || acc[3:0] > `OAG_BCD_LO_MAX) begin
         daa_fix = daa_fix | `OAG_BCD_LO_FIX;
      end
      if (daa_carry) begin
         daa_fix = daa_fix | `OAG_BCD_HI_FIX;
      end
      daa_sum = {1'b0, acc} + {1'b0, daa_fix};
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         acc <= `OAG_RST_ACC;
         condition_flags_reg <= `OAG_RST_FLAGS;
      end else begin
         if (daa_en_i) begin
            acc <= daa_sum[7:0]; // decimal_adjust_op
            condition_flags_reg[`OAG_FLAG_C] <= daa_carry;
            condition_flags_reg[`OAG_FLAG_N] <= daa_sum[7];
            condition_flags_reg[`OAG_FLAG_Z] <= (daa_sum[7:0] == 8'h00);
         end else if (add_en_i) begin
            acc <= add_sum[7:0];
            condition_flags_reg[`OAG_FLAG_H] <= add_lo[4];
            condition_flags_reg[`OAG_FLAG_C] <= add_sum[8];
            condition_flags_reg[`OAG_FLAG_V] <= (acc[7] == add_data_i[7]) && (add_sum[7] != acc[7]);
            condition_flags_reg[`OAG_FLAG_N] <= add_sum[7];
            condition_flags_reg[`OAG_FLAG_Z] <= (add_sum[7:0] == 8'h00);
         end else if (regwr_i.en && regwr_i.sel == OAG_SEL_ACC) begin
            acc <= regwr_i.data[7:0];
         end
         // Set takes priority so a simultaneous set and clear leaves interrupts off
         if (mask_set_i) begin
            condition_flags_reg[`OAG_FLAG_I] <= 1'b1;
         end else if (mask_clr_i) begin
            condition_flags_reg[`OAG_FLAG_I] <= 1'b0;
         end
      end
   end

   // Request pin crosses in from outside through two flops
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         irq_meta <= 1'b1;
         irq_sync_n <= 1'b1;
      end else begin
         irq_meta <= irq_n_i;
         irq_sync_n <= irq_meta;
      end
   end

   // Software trap stays pending until acknowledged; a new trap beats the ack
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         trap_pend <= 1'b0;
      end else if (software_trap_i) begin
         trap_pend <= 1'b1; // software_trap
      end else if (irq_ack_i) begin
         trap_pend <= 1'b0;
      end
   end

   // Trap is not maskable; pin and peripheral requests obey the mask flag
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         irq_req_o <= 1'b0;
         irq_src_o <= 7'h00;
      end else begin
         irq_req_o <= trap_pend || (!condition_flags_reg[`OAG_FLAG_I] && (!irq_sync_n || periph_req_i));
         if (trap_pend) begin
            irq_src_o <= `OAG_SRC_TRAP;
         end else if (!irq_sync_n) begin
            irq_src_o <= `OAG_SRC_EXT;
         end else begin
            irq_src_o <= periph_src_i;
         end
      end
   end

   assign acc_o = acc;
   assign index_o = idx;
   assign stack_pointer_o = stack_pointer_reg;
   assign program_counter_o = program_counter_reg;
   assign condition_flags_o = condition_flags_reg;
endmodule : oag_core

// ---- verification/oag_core_props.sv ----
// Port checker for the operand address generator
`timescale 1ns/1ps
module oag_core_props (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic cmd_valid_i,
   input wire oag_pkg::oag_cmd_t cmd_i,
   input wire logic cmd_ready_o,
   input wire logic done_o,
   input wire logic [15:0] ea_o,
   input wire oag_pkg::oag_mem_t mem_o,
   input wire logic irq_n_i,
   input wire logic software_trap_i,
   input wire logic irq_ack_i,
   input wire logic irq_req_o,
   input wire logic [6:0] irq_src_o,
   input wire logic [7:0] condition_flags_o
);
   import oag_pkg::*;
   oag_mode_t cur_mode;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   // Remember the mode of the command in flight, since cmd_i is only valid at acceptance
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         cur_mode <= OAG_INH;
      end else if (cmd_valid_i && cmd_ready_o) begin
         cur_mode <= cmd_i.mode;
      end
   end
   a_strobe_excl: assert property (!(mem_o.rd && mem_o.wr)) else $error("read and write strobes both high");
   a_strobe_len: assert property (
      $rose(mem_o.rd || mem_o.wr) |=> (mem_o.rd || mem_o.wr) ##1 !(mem_o.rd || mem_o.wr))
      else $error("strobe not held one bus cycle");
   a_rd_addr_hold: assert property (mem_o.rd && $past(mem_o.rd) |-> $stable(mem_o.addr))
      else $error("read address moved under strobe");
   a_wr_data_hold: assert property (
      mem_o.wr && $past(mem_o.wr) |-> $stable(mem_o.addr) && $stable(mem_o.wdata))
      else $error("write address or data moved under strobe");
   a_done_ready: assert property (done_o |=> cmd_ready_o) else $error("not idle after done");
   a_dir_page: assert property (done_o && cur_mode == OAG_DIR |-> ea_o[15:8] == 8'h00)
      else $error("direct address outside page zero");
   a_mask_blocks: assert property (irq_req_o && $past(condition_flags_o[3]) |-> irq_src_o == 7'h00)
      else $error("masked request passed");
   a_pin_req: assert property ((!irq_n_i && !condition_flags_o[3])[*4] |-> irq_req_o)
      else $error("low pin not requested");
   a_trap_req: assert property (software_trap_i && !irq_ack_i |-> ##[1:3] irq_req_o)
      else $error("trap not requested");
   c_move: cover property (done_o && cur_mode == OAG_MM);
   c_write: cover property ($rose(mem_o.wr));
   c_pin: cover property (irq_req_o && irq_src_o == 7'h01);
endmodule : oag_core_props

// ---- verification/oag_mem_model.sv ----
// Byte-wide memory answering the core's strobes
`timescale 1ns/1ps
module oag_mem_model (
   input wire logic mclk_i,
   input wire oag_pkg::oag_mem_t mem_i,
   output logic [7:0] rdata_o
);
   import oag_pkg::*;
   logic [7:0] mem [0:65535];
   logic [7:0] last;
   // Address-derived fill so every read has a known answer
   initial begin
      last = 8'h00;
      for (int a = 0; a < 65536; a++) begin
         mem[a] = a[7:0] ^ a[15:8] ^ 8'h5a;
      end
   end
   // Released bus shows the inverse of the last byte, never a stale match
   assign rdata_o = mem_i.rd ? mem[mem_i.addr] : ~last;
   // One byte per location
   always @(posedge mclk_i) begin
      if (mem_i.rd) begin
         last <= mem[mem_i.addr];
      end
      if (mem_i.wr) begin
         mem[mem_i.addr] <= mem_i.wdata;
      end
   end
endmodule : oag_mem_model

// ---- verification/oag_core_test.sv ----
// Self-checking bench for the operand address generator
`timescale 1ns/1ps
module oag_core_test;
   import oag_pkg::*;
   logic mclk_i, srst_i, cmd_valid_i, cmd_ready_o, done_o, add_en_i, add_carry_i, daa_en_i;
   logic mask_set_i, mask_clr_i, irq_n_i, periph_req_i, software_trap_i, irq_ack_i, irq_req_o;
   logic [15:0] operand_o, ea_o, index_o, stack_pointer_o, program_counter_o;
   logic [7:0] rdata_i, add_data_i, acc_o, condition_flags_o;
   logic [6:0] periph_src_i, irq_src_o;
   oag_cmd_t cmd_i;
   oag_mem_t mem_o;
   oag_regwr_t regwr_i;
   int err_count, checked;
   oag_core dut (.mclk_i, .srst_i, .cmd_valid_i, .cmd_i, .cmd_ready_o, .done_o, .operand_o, .ea_o, .mem_o,
      .rdata_i, .regwr_i, .add_en_i, .add_data_i, .add_carry_i, .daa_en_i, .mask_set_i, .mask_clr_i,
      .irq_n_i, .periph_req_i, .periph_src_i, .software_trap_i, .irq_ack_i, .irq_req_o, .irq_src_o,
      .acc_o, .index_o, .stack_pointer_o, .program_counter_o, .condition_flags_o);
   oag_mem_model mdl (.mclk_i, .mem_i(mem_o), .rdata_o(rdata_i));
   // Clock
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction : pat
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic end_sim();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   task automatic set_reg(input oag_sel_t sel, input logic [15:0] d);
      @(posedge mclk_i);
      regwr_i <= '{1'b1, sel, d};
      @(posedge mclk_i);
      regwr_i.en <= 1'b0;
   endtask : set_reg
   // One command; results are taken in the cycle done is seen, as it lasts one cycle
   task automatic run_cmd(input oag_mode_t m, input logic w, input logic s, input oag_mm_t mm,
         output logic [15:0] ea_s, output logic [15:0] op_s);
      int n;
      @(posedge mclk_i);
      cmd_i <= '{m, w, s, mm};
      cmd_valid_i <= 1'b1;
      @(posedge mclk_i);
      check("ready", {15'h0000, cmd_ready_o}, 16'h0001);
      cmd_valid_i <= 1'b0;
      n = 0;
      while (done_o !== 1'b1 && n < 100) begin
         @(posedge mclk_i);
         n++;
      end
      check("done", {15'h0000, done_o}, 16'h0001);
      ea_s = ea_o;
      op_s = operand_o;
      repeat (2) @(posedge mclk_i);
   endtask : run_cmd
   task automatic alu(input logic d, input logic [7:0] v);
      @(posedge mclk_i);
      add_en_i <= ~d;
      daa_en_i <= d;
      add_data_i <= v;
      @(posedge mclk_i);
      add_en_i <= 1'b0;
      daa_en_i <= 1'b0;
      @(posedge mclk_i);
   endtask : alu
   task automatic irq_ctl(input logic [3:0] p);
      @(posedge mclk_i);
      {mask_clr_i, mask_set_i, software_trap_i, irq_ack_i} <= p;
      @(posedge mclk_i);
      {mask_clr_i, mask_set_i, software_trap_i, irq_ack_i} <= 4'h0;
      repeat (5) @(posedge mclk_i);
   endtask : irq_ctl
   task automatic t_regs();
      check("flags", {8'h00, condition_flags_o}, 16'h0008);
      check("sp", stack_pointer_o, 16'h00ff);
      set_reg(OAG_SEL_IDXH, 16'h0012);
      set_reg(OAG_SEL_IDXL, 16'h0034);
      set_reg(OAG_SEL_IDXH, 16'h00ab);
      @(posedge mclk_i);
      check("index", index_o, 16'hab34);
   endtask : t_regs
   // Every addressing mode except memory-to-memory from pc 0100 with index ffff so sums and increments wrap
   task automatic t_modes();
      oag_mode_t mt [10] = '{OAG_DIR, OAG_EXT, OAG_IMM, OAG_IMM, OAG_IX0, OAG_IX1, OAG_IX2, OAG_IXP0,
         OAG_IXP1, OAG_INH};
      logic [15:0] et [10] = '{16'h0040, 16'h4020, 16'h0040, 16'h4020, 16'hffff, 16'h003f, 16'h401f,
         16'hffff, 16'h003f, 16'h0000};
      int pt [10] = '{1, 2, 1, 2, 0, 1, 2, 0, 1, 0};
      logic [15:0] ea_s, op_s;
      mdl.mem[16'h0100] = 8'h40;
      mdl.mem[16'h0101] = 8'h20;
      for (int i = 0; i < 10; i++) begin
         set_reg(OAG_SEL_PC, 16'h0100);
         set_reg(OAG_SEL_IDX, 16'hffff);
         run_cmd(mt[i], i == 3, 1'b0, OAG_MM_IMM_DIR, ea_s, op_s);
         if (i == 2 || i == 3) begin
            check("imm", op_s, et[i]);
         end else if (i != 9) begin
            check("ea", ea_s, et[i]);
            check("operand", op_s, {8'h00, pat(et[i])});
         end
         check("pc", program_counter_o, 16'h0100 + 16'(pt[i]));
         check("index", index_o, (i == 7 || i == 8) ? 16'h0000 : 16'hffff);
      end
   endtask : t_modes
   task automatic t_store();
      logic [15:0] ea_s, op_s;
      set_reg(OAG_SEL_ACC, 16'h003c);
      set_reg(OAG_SEL_PC, 16'h0100);
      mdl.mem[16'h0100] = 8'h44;
      run_cmd(OAG_DIR, 1'b0, 1'b1, OAG_MM_IMM_DIR, ea_s, op_s);
      check("stored", {mdl.mem[16'h0045], mdl.mem[16'h0044]}, {pat(16'h0045), 8'h3c});
   endtask : t_store
   // All four moves; the accumulator must come through untouched
   task automatic t_moves();
      logic [15:0] ea_s, op_s;
      logic [15:0] dst [4] = '{16'h0050, 16'h0051, 16'h0052, 16'h0070};
      logic [7:0] b0 [4] = '{8'ha5, 8'h60, 8'h52, 8'h61};
      logic [7:0] val [4] = '{8'ha5, pat(16'h0060), pat(16'h0070), pat(16'h0061)};
      set_reg(OAG_SEL_ACC, 16'h00c3);
      for (int i = 0; i < 4; i++) begin
         mdl.mem[16'h0100] = b0[i];
         mdl.mem[16'h0101] = dst[i][7:0];
         set_reg(OAG_SEL_PC, 16'h0100);
         set_reg(OAG_SEL_IDX, 16'h0070);
         run_cmd(OAG_MM, 1'b0, 1'b0, oag_mm_t'(i), ea_s, op_s);
         check("move", {8'h00, mdl.mem[dst[i]]}, {8'h00, val[i]});
         check("index", index_o, (i > 1) ? 16'h0071 : 16'h0070);
      end
      check("acc", {8'h00, acc_o}, 16'h00c3);
   endtask : t_moves
   task automatic t_arith();
      set_reg(OAG_SEL_ACC, 16'h000f);
      alu(1'b0, 8'h01);
      check("half", {15'h0000, condition_flags_o[4]}, 16'h0001);
      alu(1'b1, 8'h00);
      check("adj", {8'h00, acc_o}, 16'h0016);
      set_reg(OAG_SEL_ACC, 16'h0090);
      alu(1'b0, 8'h90);
      alu(1'b1, 8'h00);
      check("adj", {8'h00, acc_o}, 16'h0080);
   endtask : t_arith
   task automatic t_irq();
      @(posedge mclk_i);
      irq_n_i <= 1'b0;
      irq_ctl(4'h0);
      check("masked", {15'h0000, irq_req_o}, 16'h0000);
      irq_ctl(4'h8);
      check("pin", {8'h00, irq_req_o, irq_src_o}, 16'h0081);
      irq_n_i <= 1'b1;
      irq_ctl(4'h4);
      check("idle", {15'h0000, irq_req_o}, 16'h0000);
      irq_ctl(4'h2);
      check("trap", {8'h00, irq_req_o, irq_src_o}, 16'h0080);
      irq_ctl(4'h1);
      check("ack", {15'h0000, irq_req_o}, 16'h0000);
      // Peripheral source passes its own number once the mask is cleared
      periph_src_i <= 7'h7f;
      periph_req_i <= 1'b1;
      irq_ctl(4'h0);
      check("periph masked", {15'h0000, irq_req_o}, 16'h0000);
      irq_ctl(4'h8);
      check("periph", {8'h00, irq_req_o, irq_src_o}, 16'h00ff);
      periph_req_i <= 1'b0;
   endtask : t_irq
   // Main sequence
   initial begin
      srst_i = 1'b1;
      cmd_valid_i = 1'b0;
      cmd_i = '0;
      regwr_i = '0;
      add_data_i = 8'h00;
      periph_src_i = 7'h00;
      irq_n_i = 1'b1;
      {add_en_i, daa_en_i, mask_set_i, mask_clr_i, software_trap_i, irq_ack_i, periph_req_i, add_carry_i} = '0;
      repeat (10) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(posedge mclk_i);
      t_regs();
      t_modes();
      t_store();
      t_moves();
      t_arith();
      t_irq();
      end_sim();
   end
   // Watchdog well beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge mclk_i);
      err_count++;
      end_sim();
   end
endmodule : oag_core_test
bind oag_core oag_core_props u_props (.mclk_i, .srst_i, .cmd_valid_i, .cmd_i, .cmd_ready_o, .done_o, .ea_o,
   .mem_o, .irq_n_i, .software_trap_i, .irq_ack_i, .irq_req_o, .irq_src_o, .condition_flags_o);
